// File: bit_manipulation_unit.sv
// Purpose: Executes single-bit instructions on a register or memory byte
// Assumes: Core supplies operand, index sources and memory handshake
// Notes: Byte-modifying ops on memory use a read-modify-write sequence; flag and test ops only read
//
// Functional notes
// - Set forces selected bit to one
// - Clear forces selected bit to zero
// - Invert complements the selected bit only
// - Test loads zero flag with inverted bit
// - Index from immediate or register low bits
// - AND carry with selected bit
// - AND carry with inverted bit
// - OR carry with selected bit
// - OR carry with inverted bit
// - XOR carry with selected bit
// - XOR carry with inverted bit
// - Load selected bit into carry
// - Load inverted bit into carry
// - Store carry into selected bit
// - Store inverted carry into selected bit
// - Inverted variants use immediate index only
// - Result flag is the carry bit
`timescale 1ns/1ps
module bit_manipulation_unit
    import bmu_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Instruction request
    input wire logic start,
    input wire logic [3:0] op_code,
    input wire logic use_reg_index,
    input wire logic [2:0] imm_index,
    input wire logic [7:0] index_reg,
    input wire logic operand_in_mem,
    input wire logic [7:0] reg_operand,
    output logic busy,
    output logic done,
    // General register write-back
    output logic [7:0] reg_result,
    output logic reg_write,
    // Memory byte access
    output logic mem_read,
    output logic mem_write,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // Carry loaded from, and both flags returned to, the condition code register
    input wire logic [7:0] ccr_in,
    output logic carry_flag,
    output logic zero_flag,
    output logic carry_write,
    output logic zero_write
);
    bmu_ops_if ops();
    bmu_state_type state;
    bmu_state_type next_state;
    bmu_op_type op;
    logic [2:0] index;
    logic [7:0] operand;
    logic in_mem;
    logic carry_in;
    logic [2:0] start_index;
    logic inverted_op;
    logic take;

    bmu_datapath u_dp (
        .ops(ops)
    );

    // Inverted variants ignore the register index select
    assign inverted_op = (op_code == BMU_AND_INVERTED_BIT) ||
        (op_code == BMU_OR_INVERTED_BIT) ||
        (op_code == BMU_XOR_INVERTED_BIT) ||
        (op_code == BMU_LOAD_INVERTED_BIT) ||
        (op_code == BMU_STORE_INVERTED_FLAG);
    assign start_index = (use_reg_index && !inverted_op) ?
        index_reg[2:0] : imm_index;
    assign take = start && (state == BMU_IDLE);
    assign busy = (state != BMU_IDLE);

    // Datapath feed from latched instruction
    assign ops.op = op;
    assign ops.operand = operand;
    assign ops.index = index;
    assign ops.carry_in = carry_in;

    // Sequencer: register operands execute in one MODIFY cycle
    always_comb begin
        next_state = state;
        case (state)
            BMU_IDLE: begin
                if (start) begin
                    next_state = operand_in_mem ? BMU_READ : BMU_MODIFY;
                end
            end
            BMU_READ: begin
                if (mem_ack) begin
                    next_state = BMU_MODIFY;
                end
            end
            BMU_MODIFY: begin
                if (in_mem && ops.writes_byte) begin
                    next_state = BMU_WRITE;
                end else begin
                    next_state = BMU_IDLE;
                end
            end
            BMU_WRITE: begin
                if (mem_ack) begin
                    next_state = BMU_IDLE;
                end
            end
            default: next_state = BMU_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= BMU_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Instruction latch; carry comes from the condition code register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            op <= BMU_SET_BIT_OP;
            index <= 3'h0;
            in_mem <= 1'b0;
            carry_in <= BMU_CARRY_RST;
        end else if (take) begin
            op <= bmu_op_type'(op_code);
            index <= start_index;
            in_mem <= operand_in_mem;
            carry_in <= ccr_in[BMU_CCR_C_POS];
        end
    end

    // Operand byte: register value, or whole byte fetched from memory
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            operand <= BMU_BYTE_RST;
        end else if (take) begin
            operand <= reg_operand;
        end else if (state == BMU_READ && mem_ack) begin
            operand <= mem_rdata;
        end
    end

    // Results and write strobes, registered at MODIFY
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_result <= BMU_BYTE_RST;
            mem_wdata <= BMU_BYTE_RST;
            reg_write <= 1'b0;
            carry_flag <= BMU_CARRY_RST;
            zero_flag <= BMU_ZERO_RST;
            carry_write <= 1'b0;
            zero_write <= 1'b0;
        end else begin
            reg_write <= 1'b0;
            carry_write <= 1'b0;
            zero_write <= 1'b0;
            if (state == BMU_MODIFY) begin
                reg_result <= ops.result;
                mem_wdata <= ops.result;
                reg_write <= ops.writes_byte && !in_mem;
                carry_flag <= ops.carry_out;
                carry_write <= ops.writes_carry;
                zero_flag <= ops.zero_out;
                zero_write <= ops.writes_zero;
            end
        end
    end

    // Memory strobes held until acknowledge
    assign mem_read = (state == BMU_READ);
    assign mem_write = (state == BMU_WRITE);

    // Done pulse at the end of each instruction
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
        end else begin
            done <= (busy && next_state == BMU_IDLE);
        end
    end
endmodule // bit_manipulation_unit

// File: bmu_pkg.sv
// Purpose: Shared constants and types for the bit manipulation unit
// Assumes: Byte operands, 3-bit bit index, one core clock
// Notes: Operation codes are local to this block
package bmu_pkg;

    localparam int BMU_DATA_W = 8;
    localparam int BMU_IDX_W = 3;
    localparam logic BMU_CARRY_RST = 1'b0;
    localparam logic BMU_ZERO_RST = 1'b0;
    localparam logic [7:0] BMU_BYTE_RST = 8'h00;
    localparam int BMU_CCR_C_POS = 0;
    localparam int BMU_CCR_Z_POS = 2;

    // Operation selector, one code per bit instruction
    typedef enum logic [3:0] {
        BMU_SET_BIT_OP = 4'h0,
        BMU_CLEAR_BIT_OP = 4'h1,
        BMU_INVERT_BIT_OP = 4'h2,
        BMU_TEST_BIT_OP = 4'h3,
        BMU_AND_BIT_INTO_FLAG = 4'h4,
        BMU_AND_INVERTED_BIT = 4'h5,
        BMU_OR_BIT_INTO_FLAG = 4'h6,
        BMU_OR_INVERTED_BIT = 4'h7,
        BMU_XOR_BIT_INTO_FLAG = 4'h8,
        BMU_XOR_INVERTED_BIT = 4'h9,
        BMU_LOAD_BIT_TO_FLAG = 4'hA,
        BMU_LOAD_INVERTED_BIT = 4'hB,
        BMU_STORE_FLAG_TO_BIT = 4'hC,
        BMU_STORE_INVERTED_FLAG = 4'hD
    } bmu_op_type;

    // Sequencer states, Gray coded along idle-read-modify-write
    typedef enum logic [1:0] {
        BMU_IDLE = 2'b00,
        BMU_READ = 2'b01,
        BMU_MODIFY = 2'b11,
        BMU_WRITE = 2'b10
    } bmu_state_type;

endpackage

// File: bmu_ops_if.sv
// Purpose: Carries one bit operation between sequencer and datapath
// Assumes: Single clock domain
// Notes: Combinational path, no storage
`timescale 1ns/1ps
interface bmu_ops_if;
    import bmu_pkg::*;
    bmu_op_type op;
    logic [7:0] operand;
    logic [2:0] index;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    logic zero_out;
    logic writes_byte;
    logic writes_carry;
    logic writes_zero;
    modport seq (output op, operand, index, carry_in,
                 input result, carry_out, zero_out,
                 writes_byte, writes_carry, writes_zero);
    modport dp (input op, operand, index, carry_in,
                output result, carry_out, zero_out,
                writes_byte, writes_carry, writes_zero);
endinterface // bmu_ops_if

// File: bmu_datapath.sv
// Purpose: Combinational bit select, modify and flag logic
// Assumes: Operation code valid whenever the sequencer looks
// Notes: Unknown codes write nothing
`timescale 1ns/1ps
module bmu_datapath
    import bmu_pkg::*;
(
    // Operation channel
    bmu_ops_if.dp ops
);
    logic [7:0] onehot;
    logic sel_bit;
    logic [7:0] set_byte;
    logic [7:0] clr_byte;
    logic [7:0] inv_byte;
    logic [7:0] put_c;
    logic [7:0] put_nc;
    logic is_mod;
    logic is_flag;

    // Bit selection by a one-hot mask
    assign onehot = 8'h01 << ops.index;
    assign sel_bit = ops.operand[ops.index];

    // Byte results; only the selected bit moves
    assign set_byte = ops.operand | onehot;
    assign clr_byte = ops.operand & ~onehot;
    assign inv_byte = ops.operand ^ onehot;
    assign put_c = ops.carry_in ? set_byte : clr_byte;
    assign put_nc = ops.carry_in ? clr_byte : set_byte;

    assign ops.result = (ops.op == BMU_SET_BIT_OP) ? set_byte :
        (ops.op == BMU_CLEAR_BIT_OP) ? clr_byte :
        (ops.op == BMU_INVERT_BIT_OP) ? inv_byte :
        (ops.op == BMU_STORE_FLAG_TO_BIT) ? put_c :
        (ops.op == BMU_STORE_INVERTED_FLAG) ? put_nc : ops.operand;

    // Carry results of the flag-combining group
    assign ops.carry_out =
        (ops.op == BMU_AND_BIT_INTO_FLAG) ? (ops.carry_in & sel_bit) :
        (ops.op == BMU_AND_INVERTED_BIT) ? (ops.carry_in & ~sel_bit) :
        (ops.op == BMU_OR_BIT_INTO_FLAG) ? (ops.carry_in | sel_bit) :
        (ops.op == BMU_OR_INVERTED_BIT) ? (ops.carry_in | ~sel_bit) :
        (ops.op == BMU_XOR_BIT_INTO_FLAG) ? (ops.carry_in ^ sel_bit) :
        (ops.op == BMU_XOR_INVERTED_BIT) ? (ops.carry_in ^ ~sel_bit) :
        (ops.op == BMU_LOAD_BIT_TO_FLAG) ? sel_bit :
        (ops.op == BMU_LOAD_INVERTED_BIT) ? ~sel_bit :
        ops.carry_in;

    // Test outcome: zero flag set when the bit is clear
    assign ops.zero_out = ~sel_bit;

    // Destination steering, each operation touches only its own target
    assign is_mod = (ops.op == BMU_SET_BIT_OP) ||
        (ops.op == BMU_CLEAR_BIT_OP) || (ops.op == BMU_INVERT_BIT_OP) ||
        (ops.op == BMU_STORE_FLAG_TO_BIT) ||
        (ops.op == BMU_STORE_INVERTED_FLAG);
    assign is_flag = (ops.op >= BMU_AND_BIT_INTO_FLAG) &&
        (ops.op <= BMU_LOAD_INVERTED_BIT);
    assign ops.writes_byte = is_mod;
    assign ops.writes_carry = is_flag;
    assign ops.writes_zero = (ops.op == BMU_TEST_BIT_OP);
endmodule // bmu_datapath

// File: bmu_checker_sva.sv
// Purpose: Port-level timing and result checks for the bit unit
// Assumes: Codes E and F may be issued and must write nothing
// Notes: Bound to the top module below the checker
`timescale 1ns/1ps
module bmu_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Request side
    input wire logic start,
    input wire logic [3:0] op_code,
    input wire logic use_reg_index,
    input wire logic [2:0] imm_index,
    input wire logic operand_in_mem,
    input wire logic busy,
    input wire logic done,
    // Result side
    input wire logic [7:0] reg_result,
    input wire logic reg_write,
    input wire logic mem_read,
    input wire logic mem_write,
    input wire logic mem_ack,
    input wire logic carry_write,
    input wire logic zero_write
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Register request taken with an immediate index
    wire take_reg = start && !busy && !operand_in_mem && !use_reg_index;
    property p_bit(logic [3:0] code, logic val);
        logic [2:0] k;
        (take_reg && op_code == code, k = imm_index)
            |-> ##2 reg_write && reg_result[k] == val;
    endproperty
    chk_reg_two_cycles: assert property (take_reg |=> busy ##1 done)
        else $error("register op timing off");
    chk_set_forces_one: assert property (p_bit(4'h0, 1'b1))
        else $error("set bit not one");
    chk_clear_forces_zero: assert property (p_bit(4'h1, 1'b0))
        else $error("clear bit not zero");
    chk_read_holds: assert property
        (mem_read && !mem_ack |=> mem_read)
        else $error("memory read dropped early");
    chk_done_after_write: assert property
        (mem_write && mem_ack |=> done)
        else $error("no done after write");
    chk_flag_no_byte: assert property
        (carry_write |-> !reg_write && !mem_write)
        else $error("flag op wrote a byte");
    chk_test_no_byte: assert property
        (zero_write |-> !reg_write && !carry_write)
        else $error("test op wrote more");
    chk_write_with_done: assert property (reg_write |-> done)
        else $error("register write without done");
    chk_mem_exclusive: assert property (!(mem_read && mem_write))
        else $error("read and write together");
    // Main scenarios reached
    cov_mem_write: cover property (mem_write && mem_ack);
    cov_test: cover property (zero_write);
    cov_flag: cover property (carry_write && done);
endmodule // bmu_checker

bind bit_manipulation_unit bmu_checker bmu_checker_inst (.clock(clock),
    .nrst(nrst), .start(start), .op_code(op_code),
    .use_reg_index(use_reg_index), .imm_index(imm_index),
    .operand_in_mem(operand_in_mem), .busy(busy), .done(done),
    .reg_result(reg_result), .reg_write(reg_write), .mem_read(mem_read),
    .mem_write(mem_write), .mem_ack(mem_ack), .carry_write(carry_write),
    .zero_write(zero_write));

// File: tb.sv
// Purpose: Self-checking bench for the bit manipulation unit
// Assumes: Memory answers with random delay, data only under ack
// Notes: Expected outcome {byte, wb, carry, wc, zero, wz} per op
`timescale 1ns/1ps
module tb;
    import bmu_pkg::*;
    logic clock, nrst, start, use_reg_index, operand_in_mem, mem_ack;
    logic [3:0] op_code;
    logic [2:0] imm_index;
    logic [7:0] index_reg, reg_operand, mem_rdata, ccr_in, mem_byte;
    logic busy, done, reg_write, mem_read, mem_write;
    logic carry_flag, zero_flag, carry_write, zero_write;
    logic [7:0] reg_result, mem_wdata;
    logic [12:0] obs, want;
    logic [12:0] notes[$];
    logic [31:0] r;
    int err_count, total_checks, cycles;

    bit_manipulation_unit bit_manipulation_unit_inst (.clock(clock),
        .nrst(nrst), .start(start), .op_code(op_code),
        .use_reg_index(use_reg_index), .imm_index(imm_index),
        .index_reg(index_reg), .operand_in_mem(operand_in_mem),
        .reg_operand(reg_operand), .busy(busy), .done(done),
        .reg_result(reg_result), .reg_write(reg_write), .mem_read(mem_read),
        .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .ccr_in(ccr_in), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .carry_write(carry_write),
        .zero_write(zero_write));

    always #12.5 clock = ~clock;

    // Reference outcome worked out from the bit rules
    function automatic logic [12:0] model(logic [3:0] op, logic [7:0] b,
        logic [2:0] k, logic c);
        logic x, f;
        logic [7:0] v;
        x = b[k];
        v = b;
        v[k] = op == 4'h0 ? 1'b1 : op == 4'h1 ? 1'b0 : op == 4'h2 ? ~x
            : op == 4'hC ? c : ~c;
        case (op)
            4'h4: f = c & x;
            4'h5: f = c & ~x;
            4'h6: f = c | x;
            4'h7: f = c | ~x;
            4'h8: f = c ^ x;
            4'h9: f = c ^ ~x;
            4'hA: f = x;
            default: f = ~x;
        endcase
        // Undefined codes must leave byte and both flags untouched
        if (op > 4'hD) return 13'h0000;
        if (op < 4'h3 || op > 4'hB) return {v, 1'b1, 4'h0};
        if (op == 4'h3) return {8'h00, 3'h0, ~x, 1'b1};
        return {8'h00, 1'b0, f, 1'b1, 2'b00};
    endfunction

    // Issue one instruction and wait for its done cycle
    task automatic issue(logic [3:0] op, logic mem, logic ur, logic [2:0] ii,
        logic [7:0] ir, logic [7:0] b, logic [7:0] cc);
        logic [2:0] k;
        int n;
        k = (ur && !(op[0] && op > 4'h3)) ? ir[2:0] : ii;
        notes.push_back(model(op, b, k, cc[0]));
        {op_code, operand_in_mem, use_reg_index, imm_index} = {op, mem, ur, ii};
        {index_reg, ccr_in, mem_byte, reg_operand} = {ir, cc, b, mem ? ~b : b};
        start = 1'b1;
        @(posedge clock);
        #2 start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clock);
            #2 n++;
        end
        // A lost done would otherwise only shift the queue silently
        if (done !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
                done, 1'b1);
        end
    endtask

    // Memory answers after a random wait; data is junk outside ack
    always @(posedge clock) begin
        #2 mem_ack = (mem_read || mem_write) && !mem_ack && $urandom % 2;
        mem_rdata = mem_ack ? mem_byte : ~mem_byte;
    end

    // Collect strobes of one instruction, compare at its done
    always @(negedge clock) begin
        if (reg_write) obs[12:4] = {reg_result, 1'b1};
        if (mem_write && mem_ack) obs[12:4] = {mem_wdata, 1'b1};
        if (carry_write) obs[3:2] = {carry_flag, 1'b1};
        if (zero_write) obs[1:0] = {zero_flag, 1'b1};
        if (done === 1'b1) begin
            want = notes.pop_front();
            total_checks++;
            if (obs !== want) begin
                err_count++;
                $display("wrong value at %0t: got %h expected %h", $time,
                    obs, want);
            end
            obs = '0;
        end
    end

    task automatic close_out();
        // Notes never consumed mean an instruction never finished
        if (notes.size() != 0) err_count++;
        $display("checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, well above the expected thousand or so cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        {clock, nrst, start, use_reg_index, operand_in_mem, mem_ack} = '0;
        {op_code, imm_index, index_reg, reg_operand, mem_rdata, ccr_in} = '0;
        {mem_byte, obs} = '0;
        void'($urandom(32'hA0E46C78));
        repeat (8) @(posedge clock);
        #2 nrst = 1'b1;
        // Every code in register and memory, even codes at index 0, odd codes at index 7
        for (int i = 0; i < 28; i++) begin
            r = $urandom;
            issue(4'(i % 14), i >= 14, 1'b0, {3{i[0]}}, 8'h00, r[7:0],
                r[15:8]);
        end
        // Undefined codes must touch nothing, in register and memory
        issue(4'hE, 1'b0, 1'b0, 3'h5, 8'h00, 8'h5A, 8'hFF);
        issue(4'hF, 1'b1, 1'b1, 3'h2, 8'h07, 8'hA5, 8'hFF);
        // Random mix, register-sourced index included
        repeat (300) begin
            r = $urandom;
            issue(4'(r % 14), r[4], r[5], r[8:6], r[15:8], r[23:16],
                8'($urandom));
        end
        // Let the last done reach the compare before the verdict
        repeat (2) @(posedge clock);
        close_out();
    end
endmodule // tb
